// *** verilog/sct_timeout_counter.sv ***
// ETU timeout counter: one 24-bit or a 16-bit plus an 8-bit down counter
//
// Operation
// - one 24-bit or 16-bit plus 8-bit counter
// - software mode starts on control write
// - software count at zero: halt, flag, interrupt
// - 16-bit stop/restart keeps 8-bit running
// - compatible software value keeps running count
// - start bits start; 16/24-bit restart each
// - 8-bit reloads at zero except receive autostop in receive direction, wider ones stop
// - start-bit count registers load at next start
// - value 00h stops every counter
// - 05h: 8-bit autoreload, upper pair stopped
// - 61h: 16-bit software, 8-bit stopped
// - 65h: 16-bit software plus 8-bit autoreload
// - 68h: 24-bit software counter
// - 71h: 16-bit start-bit, 8-bit stopped
// - 75h: 16-bit start-bit plus 8-bit autoreload
// - 7Ch: 24-bit start-bit counter
// - 85h: 8-bit receive autostop after 12 ETU
// - E5h: 16-bit software, 8-bit receive autostop
// - F1h: 16-bit receive autostop, 8-bit stopped
// - F5h: both receive autostop, transmit start-bit
// - count one per ETU, card active
`timescale 1ns/100ps
module sct_timeout_counter (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       etu_tick,
	input  wire logic       card_active,
	input  wire logic       receive_direction,
	input  wire logic       card_serial_line,
	output logic            timeout_irq,
	output logic            timeout_flag_low,
	output logic            timeout_flag_high
);
	import sct_pkg::*;

	logic                rst_meta_r;
	logic                rst_n_r;
	logic [7:0]          ctl_r;
	logic [7:0]          hold_lo_r;
	logic [7:0]          hold_mid_r;
	logic [7:0]          hold_high_r;
	logic [7:0]          lo_cnt_r;
	logic [15:0]         hi_cnt_r;
	logic                lo_run_r;
	logic                hi_run_r;
	logic [3:0]          win_r;
	logic                flag_lo_r;
	logic                flag_hi_r;
	logic [7:0]          rdata_r;
	sct_cfg_t            cur;
	sct_cfg_t            nxt;
	logic                start_raw;
	logic                start;
	logic                tick;
	logic                wr_ctl;
	logic                rd_stat;
	logic                chain;
	logic [23:0]         cnt24;
	logic                hi_zero_next;
	logic                lo_zero_next;
	logic                hi_load;
	logic                hi_dec;
	logic                hi_term;
	logic                lo_load;
	logic                lo_dec;
	logic                lo_term;
	logic                win_end;
	logic                lo_reloads;

	// reset released through two flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	sct_start_detect #(
		.GUARD(GUARD_ETUS)
	) u_start (
		.clock           (clock),
		.rst_n           (rst_n_r),
		.card_serial_line(card_serial_line),
		.etu_tick        (etu_tick),
		.start_pulse     (start_raw)
	);

	assign tick    = etu_tick && card_active;
	assign start   = start_raw && card_active;
	assign wr_ctl  = reg_wr && (reg_addr == ADDR_MODE_CONTROL);
	assign rd_stat = reg_rd && (reg_addr == ADDR_STATUS);
	assign cur     = sct_decode(ctl_r);
	assign nxt     = sct_decode(reg_wdata);
	assign chain   = (cur.up == UP_SW24) || (cur.up == UP_SB24);
	assign cnt24   = {hi_cnt_r, lo_cnt_r};

	// host registers; the count registers are reload values only
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctl_r       <= CONTROL_RESET;
			hold_lo_r   <= COUNT_RESET;
			hold_mid_r  <= COUNT_RESET;
			hold_high_r <= COUNT_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_MODE_CONTROL: begin
					ctl_r <= reg_wdata;
				end
				ADDR_COUNT_LOW: begin
					hold_lo_r <= reg_wdata;
				end
				ADDR_COUNT_MID: begin
					hold_mid_r <= reg_wdata;
				end
				ADDR_COUNT_HIGH: begin
					hold_high_r <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// receive autostop window, opened by the first received start bit
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			win_r <= 4'h0;
		end else if (start && receive_direction && win_r == 4'h0) begin
			win_r <= AUTOSTOP_ETUS;
		end else if (win_r != 4'h0 && tick) begin
			win_r <= win_r - 4'h1;
		end
	end

	assign win_end = (win_r == 4'h1) && tick;

	// upper pair (or whole 24-bit chain) strobes
	assign hi_zero_next = chain ? (cnt24 <= 24'h000001) : (hi_cnt_r <= 16'h0001);

	always_comb begin
		hi_load = 1'b0;
		if (wr_ctl) begin
			// a compatible software value leaves a running count alone
			if ((nxt.up == UP_SW16 || nxt.up == UP_SW24) && !(hi_run_r && cur.up == nxt.up)) begin
				hi_load = 1'b1;
			end
		end else if (start) begin
			case (cur.up)
				UP_SB16, UP_SB24, UP_RX16: begin
					hi_load = 1'b1;
				end
				default: begin
					hi_load = 1'b0;
				end
			endcase
		end
	end

	assign hi_dec  = !wr_ctl && !hi_load && hi_run_r && tick;
	assign hi_term = hi_dec && hi_zero_next;

	// upper run state
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hi_run_r <= 1'b0;
		end else if (wr_ctl) begin
			if (nxt.up == UP_OFF) begin
				hi_run_r <= 1'b0;
			end else if (hi_load) begin
				hi_run_r <= 1'b1;
			end else if (nxt.up != cur.up) begin
				hi_run_r <= 1'b0;
			end
		end else if (hi_load) begin
			hi_run_r <= 1'b1;
		end else if (hi_term) begin
			hi_run_r <= 1'b0;
		end else if (win_end && cur.up == UP_RX16 && receive_direction) begin
			hi_run_r <= 1'b0;
		end
	end

	// lower 8-bit counter strobes
	assign lo_reloads   = (cur.lo == LO_RELOAD) || (cur.lo == LO_RXSTOP && !receive_direction);
	assign lo_zero_next = (lo_cnt_r <= 8'h01);

	always_comb begin
		lo_load = 1'b0;
		if (!wr_ctl && start && !lo_run_r && cur.lo != LO_OFF) begin
			lo_load = 1'b1;
		end
	end

	assign lo_dec  = !wr_ctl && !lo_load && lo_run_r && tick && !chain;
	assign lo_term = lo_dec && lo_zero_next;

	// lower run state
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			lo_run_r <= 1'b0;
		end else if (wr_ctl) begin
			if (nxt.lo != cur.lo) begin
				lo_run_r <= 1'b0;
			end
		end else if (lo_load) begin
			lo_run_r <= 1'b1;
		end else if (lo_term && !lo_reloads) begin
			lo_run_r <= 1'b0;
		end else if (win_end && cur.lo == LO_RXSTOP && receive_direction) begin
			lo_run_r <= 1'b0;
		end
	end

	// counter values
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hi_cnt_r <= 16'h0000;
			lo_cnt_r <= 8'h00;
		end else begin
			if (hi_load) begin
				hi_cnt_r <= {hold_high_r, hold_mid_r};
				// a start bit must not reuse a stale write value as a 24-bit load
				if ((wr_ctl && nxt.up == UP_SW24) || (!wr_ctl && cur.up == UP_SB24)) begin
					lo_cnt_r <= hold_lo_r;
				end
			end else if (hi_dec && chain) begin
				if (cnt24 != 24'h000000) begin
					{hi_cnt_r, lo_cnt_r} <= cnt24 - 24'h000001;
				end
			end else if (hi_dec && hi_cnt_r != 16'h0000) begin
				hi_cnt_r <= hi_cnt_r - 16'h0001;
			end
			if (lo_load || (lo_term && lo_reloads)) begin
				lo_cnt_r <= hold_lo_r;
			end else if (lo_dec && lo_cnt_r != 8'h00) begin
				lo_cnt_r <= lo_cnt_r - 8'h01;
			end
		end
	end

	// timeout flags, cleared by a status read; a new timeout wins
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			flag_lo_r <= 1'b0;
			flag_hi_r <= 1'b0;
		end else begin
			if (lo_term) begin
				flag_lo_r <= 1'b1;
			end else if (rd_stat) begin
				flag_lo_r <= 1'b0;
			end
			if (hi_term) begin
				flag_hi_r <= 1'b1;
			end else if (rd_stat) begin
				flag_hi_r <= 1'b0;
			end
		end
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_MODE_CONTROL: begin
					rdata_r <= ctl_r;
				end
				ADDR_COUNT_LOW: begin
					rdata_r <= hold_lo_r;
				end
				ADDR_COUNT_MID: begin
					rdata_r <= hold_mid_r;
				end
				ADDR_COUNT_HIGH: begin
					rdata_r <= hold_high_r;
				end
				ADDR_STATUS: begin
					rdata_r <= {4'h0, hi_run_r, lo_run_r, flag_hi_r, flag_lo_r};
				end
				default: begin
					rdata_r <= 8'h00;
				end
			endcase
		end
	end

	assign reg_rdata         = rdata_r;
	assign timeout_flag_low  = flag_lo_r;
	assign timeout_flag_high = flag_hi_r;
	assign timeout_irq       = flag_lo_r || flag_hi_r;

endmodule

// *** verilog/sct_pkg.sv ***
// shared constants, types and mode decoding for the timeout counter block
package sct_pkg;

	// register offsets on the 4-bit host address
	localparam logic [3:0] ADDR_MODE_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_COUNT_LOW    = 4'h1;
	localparam logic [3:0] ADDR_COUNT_MID    = 4'h2;
	localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h3;
	localparam logic [3:0] ADDR_STATUS       = 4'h4;

	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'h00;

	// status field positions
	localparam int STAT_FLAG_LOW  = 0;
	localparam int STAT_FLAG_HIGH = 1;
	localparam int STAT_RUN_LOW   = 2;
	localparam int STAT_RUN_HIGH  = 3;

	// control values
	localparam logic [7:0] CTL_STOP_ALL     = 8'h00;
	localparam logic [7:0] CTL_LO_RELOAD    = 8'h05;
	localparam logic [7:0] CTL_SW16         = 8'h61;
	localparam logic [7:0] CTL_SW16_RELOAD  = 8'h65;
	localparam logic [7:0] CTL_SW24         = 8'h68;
	localparam logic [7:0] CTL_SB16         = 8'h71;
	localparam logic [7:0] CTL_SB16_RELOAD  = 8'h75;
	localparam logic [7:0] CTL_SB24         = 8'h7C;
	localparam logic [7:0] CTL_LO_RXSTOP    = 8'h85;
	localparam logic [7:0] CTL_SW16_RXSTOP  = 8'hE5;
	localparam logic [7:0] CTL_RX16         = 8'hF1;
	localparam logic [7:0] CTL_RX16_RXSTOP  = 8'hF5;

	// timing counts in elementary time units
	localparam logic [3:0] AUTOSTOP_ETUS = 4'hC;
	localparam logic [3:0] GUARD_ETUS    = 4'hA;

	typedef enum logic [1:0] {
		LO_OFF,
		LO_RELOAD,
		LO_RXSTOP
	} sct_lo_mode_t;

	typedef enum logic [2:0] {
		UP_OFF,
		UP_SW16,
		UP_SB16,
		UP_RX16,
		UP_SW24,
		UP_SB24
	} sct_up_mode_t;

	typedef struct packed {
		sct_up_mode_t up;
		sct_lo_mode_t lo;
	} sct_cfg_t;

	// unlisted control values stop everything but are still stored
	function automatic sct_cfg_t sct_decode(input logic [7:0] v);
		sct_cfg_t c;
		c.up = UP_OFF;
		c.lo = LO_OFF;
		case (v)
			CTL_LO_RELOAD: begin
				c.lo = LO_RELOAD;
			end
			CTL_SW16: begin
				c.up = UP_SW16;
			end
			CTL_SW16_RELOAD: begin
				c.up = UP_SW16;
				c.lo = LO_RELOAD;
			end
			CTL_SW24: begin
				c.up = UP_SW24;
			end
			CTL_SB16: begin
				c.up = UP_SB16;
			end
			CTL_SB16_RELOAD: begin
				c.up = UP_SB16;
				c.lo = LO_RELOAD;
			end
			CTL_SB24: begin
				c.up = UP_SB24;
			end
			CTL_LO_RXSTOP: begin
				c.lo = LO_RXSTOP;
			end
			CTL_SW16_RXSTOP: begin
				c.up = UP_SW16;
				c.lo = LO_RXSTOP;
			end
			CTL_RX16: begin
				c.up = UP_RX16;
			end
			CTL_RX16_RXSTOP: begin
				c.up = UP_RX16;
				c.lo = LO_RXSTOP;
			end
			default: begin
				c.up = UP_OFF;
				c.lo = LO_OFF;
			end
		endcase
		return c;
	endfunction

endpackage

// *** verilog/sct_start_detect.sv ***
// start bit detector on the card serial line
`timescale 1ns/100ps
module sct_start_detect #(
	parameter logic [3:0] GUARD = sct_pkg::GUARD_ETUS
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic card_serial_line,
	input  wire logic etu_tick,
	output logic      start_pulse
);
	import sct_pkg::*;

	if (GUARD == 4'h0) begin : g_guard_check
		$error("guard must be at least one etu");
	end

	logic       sync1_r;
	logic       sync2_r;
	logic       prev_r;
	logic       armed_r;
	logic [3:0] guard_r;

	// two stages before anything looks at the pin
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			prev_r  <= 1'b1;
		end else begin
			sync1_r <= card_serial_line;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign start_pulse = armed_r && prev_r && !sync2_r;

	// zero data bits inside a character must not look like new start bits
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			armed_r <= 1'b0;
			guard_r <= 4'h0;
		end else if (start_pulse) begin
			armed_r <= 1'b0;
			guard_r <= GUARD;
		end else if (guard_r != 4'h0) begin
			if (etu_tick) begin
				guard_r <= guard_r - 4'h1;
			end
		end else if (sync2_r) begin
			armed_r <= 1'b1;
		end
	end

endmodule

// *** bench/sct_timeout_counter_sva.sv ***
// port assertions for the timeout counter
`timescale 1ns/100ps
module sct_timeout_counter_sva
	import sct_pkg::*;
(
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       etu_tick,
	input wire logic       card_active,
	input wire logic       receive_direction,
	input wire logic       card_serial_line,
	input wire logic       timeout_irq,
	input wire logic       timeout_flag_low,
	input wire logic       timeout_flag_high
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence s_stop_wr;
		reg_wr && reg_addr == ADDR_MODE_CONTROL && reg_wdata == CTL_STOP_ALL;
	endsequence
	sequence s_stat_rd;
		reg_rd && reg_addr == ADDR_STATUS;
	endsequence

	a_irq_flag_or: assert property (timeout_irq == (timeout_flag_low || timeout_flag_high))
		else $error("irq differs from flags");
	a_low_after_tick: assert property ($rose(timeout_flag_low) |-> $past(etu_tick && card_active))
		else $error("low flag without tick");
	a_high_after_tick: assert property ($rose(timeout_flag_high) |-> $past(etu_tick && card_active))
		else $error("high flag without tick");
	a_stop_all_quiet: assert property (s_stop_wr |=> (!$rose(timeout_flag_low) && !$rose(timeout_flag_high))[*8])
		else $error("timeout after stop");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_STATUS |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_status_flags: assert property (s_stat_rd |=> reg_rdata[1:0] == $past({timeout_flag_high, timeout_flag_low}))
		else $error("status flags wrong");
	a_flag_held: assert property ($fell(timeout_flag_low) || $fell(timeout_flag_high) |-> $past(reg_rd && reg_addr == ADDR_STATUS))
		else $error("flag dropped without read");
	a_idle_no_timeout: assert property (!card_active |=> !$rose(timeout_flag_low) && !$rose(timeout_flag_high))
		else $error("timeout while card idle");
endmodule

bind sct_timeout_counter sct_timeout_counter_sva u_sva (
	.clock            (clock),
	.reset_n          (reset_n),
	.reg_addr         (reg_addr),
	.reg_wdata        (reg_wdata),
	.reg_wr           (reg_wr),
	.reg_rd           (reg_rd),
	.reg_rdata        (reg_rdata),
	.etu_tick         (etu_tick),
	.card_active      (card_active),
	.receive_direction(receive_direction),
	.card_serial_line (card_serial_line),
	.timeout_irq      (timeout_irq),
	.timeout_flag_low (timeout_flag_low),
	.timeout_flag_high(timeout_flag_high)
);

// *** bench/sct_card_model.sv ***
// card side model: etu ticks and start bits on the serial line
`timescale 1ns/100ps
module sct_card_model (
	input  wire logic clock,
	output logic      etu_tick,
	output logic      card_serial_line
);
	initial begin
		etu_tick = 1'b0;
		card_serial_line = 1'b1;
	end
	// one-cycle ticks with a gap, as a divider output
	task automatic tick(input int n);
		repeat (n) begin
			@(negedge clock);
			etu_tick = 1'b1;
			@(negedge clock);
			etu_tick = 1'b0;
		end
	endtask
	// held low past the synchroniser, then back to the pulled-up idle level
	task automatic start_bit();
		@(negedge clock);
		card_serial_line = 1'b0;
		repeat (5) @(negedge clock);
		card_serial_line = 1'b1;
	endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the timeout counter
`timescale 1ns/100ps
module testbench;
	import sct_pkg::*;
	logic       clock;
	logic       reset_n;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       etu_tick;
	logic       card_active;
	logic       receive_direction;
	logic       card_serial_line;
	logic       timeout_irq;
	logic       timeout_flag_low;
	logic       timeout_flag_high;
	int         fail_count;
	int         checked;
	logic [7:0] codes [12] = '{8'h00, 8'h05, 8'h61, 8'h65, 8'h68, 8'h71, 8'h75, 8'h7C, 8'h85, 8'hE5, 8'hF1, 8'hF5};

	sct_timeout_counter u_sct_timeout_counter (
		.clock            (clock),
		.reset_n          (reset_n),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata),
		.etu_tick         (etu_tick),
		.card_active      (card_active),
		.receive_direction(receive_direction),
		.card_serial_line (card_serial_line),
		.timeout_irq      (timeout_irq),
		.timeout_flag_low (timeout_flag_low),
		.timeout_flag_high(timeout_flag_high)
	);
	sct_card_model u_sct_card_model (
		.clock           (clock),
		.etu_tick        (etu_tick),
		.card_serial_line(card_serial_line)
	);

	initial clock = 1'b0;
	always #2 clock = ~clock;

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end

	// map: 0 control, 1 low, 2 mid, 3 high, 4 status {run_hi,run_lo,flag_hi,flag_lo}
	initial begin
		fail_count = 0;
		checked = 0;
		reset_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		card_active = 1'b1;
		receive_direction = 1'b0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		repeat (3) @(negedge clock);
		for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00);
		foreach (codes[i]) begin
			wr(4'h0, codes[i]);
			rd(4'h0, codes[i]);
		end
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h2, 8'h03);
		rd(4'h2, 8'h03);
		wr(4'h0, CTL_SW16);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(2);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		rd(4'h4, 8'h00);
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h2, 8'h04);
		wr(4'h0, CTL_SW16);
		u_sct_card_model.tick(2);
		wr(4'h0, CTL_SW16_RELOAD);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h1, 8'h03);
		wr(4'h0, CTL_LO_RELOAD);
		u_sct_card_model.start_bit();
		rd(4'h4, 8'h04);
		u_sct_card_model.tick(3);
		rd(4'h4, 8'h05);
		u_sct_card_model.tick(3);
		rd(4'h4, 8'h05);
		wr(4'h0, CTL_SW16_RELOAD);
		rd(4'h4, 8'h0C);
		wr(4'h0, CTL_LO_RELOAD);
		rd(4'h4, 8'h04);
		wr(4'h0, CTL_STOP_ALL);
		rd(4'h4, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h01);
		wr(4'h0, CTL_SW24);
		u_sct_card_model.tick(255);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h2, 8'h02);
		wr(4'h0, CTL_SB16);
		rd(4'h4, 8'h00);
		u_sct_card_model.start_bit();
		u_sct_card_model.tick(1);
		wr(4'h2, 8'h05);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		u_sct_card_model.tick(9);
		u_sct_card_model.start_bit();
		u_sct_card_model.tick(4);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h1, 8'h14);
		u_sct_card_model.tick(6);
		receive_direction = 1'b1;
		wr(4'h0, CTL_LO_RXSTOP);
		u_sct_card_model.start_bit();
		u_sct_card_model.tick(12);
		rd(4'h4, 8'h00);
		u_sct_card_model.tick(10);
		rd(4'h4, 8'h00);
		receive_direction = 1'b0;
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h2, 8'h01);
		wr(4'h0, CTL_SW16);
		card_active = 1'b0;
		u_sct_card_model.tick(3);
		rd(4'h4, 8'h08);
		card_active = 1'b1;
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h1, 8'h02);
		wr(4'h2, 8'h04);
		wr(4'h0, CTL_SB16_RELOAD);
		rd(4'h4, 8'h00);
		u_sct_card_model.start_bit();
		rd(4'h4, 8'h0C);
		u_sct_card_model.tick(2);
		rd(4'h4, 8'h0D);
		u_sct_card_model.tick(2);
		rd(4'h4, 8'h07);
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h1, 8'h03);
		wr(4'h2, 8'h00);
		wr(4'h0, CTL_SB24);
		u_sct_card_model.tick(6);
		u_sct_card_model.start_bit();
		u_sct_card_model.tick(2);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(1);
		rd(4'h4, 8'h02);
		receive_direction = 1'b1;
		wr(4'h0, CTL_STOP_ALL);
		wr(4'h1, 8'h10);
		wr(4'h2, 8'h03);
		wr(4'h0, CTL_SW16_RXSTOP);
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(7);
		rd(4'h4, 8'h02);
		u_sct_card_model.start_bit();
		rd(4'h4, 8'h04);
		u_sct_card_model.tick(12);
		rd(4'h4, 8'h00);
		wr(4'h2, 8'h20);
		wr(4'h0, CTL_RX16);
		u_sct_card_model.start_bit();
		rd(4'h4, 8'h08);
		u_sct_card_model.tick(12);
		rd(4'h4, 8'h00);
		receive_direction = 1'b0;
		wr(4'h1, 8'h02);
		wr(4'h2, 8'h05);
		wr(4'h0, CTL_RX16_RXSTOP);
		u_sct_card_model.start_bit();
		u_sct_card_model.tick(2);
		rd(4'h4, 8'h0D);
		u_sct_card_model.tick(3);
		rd(4'h4, 8'h07);
		wr(4'h0, CTL_STOP_ALL);
		rd(4'h4, 8'h00);
		receive_direction = 1'b1;
		wr(4'h0, CTL_RX16_RXSTOP);
		u_sct_card_model.tick(5);
		u_sct_card_model.start_bit();
		u_sct_card_model.tick(2);
		rd(4'h4, 8'h09);
		wr(4'h0, CTL_STOP_ALL);
		rd(4'h4, 8'h00);
		tally_and_finish();
	end
endmodule
